// *** verilog/lmis_defines.svh ***
`ifndef LMIS_DEFINES_SVH
`define LMIS_DEFINES_SVH
`define LMIS_BANK_W 5
`define LMIS_PAGE_W 7
`define LMIS_PTR_W 16
`define LMIS_BANK_RST 5'h00
`define LMIS_PAGE_RST 7'h00
`define LMIS_ACC_RST 8'h00
`define LMIS_OPT_RST 8'hFF
`define LMIS_PTR_RST 16'h0000
`define LMIS_MODE_PREINC 2'b00
`define LMIS_MODE_PREDEC 2'b01
`define LMIS_MODE_POSTINC 2'b10
`define LMIS_MODE_POSTDEC 2'b11
`define LMIS_OFS_MIN (-32)
`define LMIS_OFS_MAX 31
`define LMIS_SRST_CYCLES 2
`endif

// *** verilog/lmis_pkg.sv ***
package lmis_pkg;
  typedef enum logic [3:0] {
    LMIS_OP_NOP = 4'h0,
    LMIS_OP_LIT_BANK = 4'h1,
    LMIS_OP_LIT_PAGE = 4'h2,
    LMIS_OP_LIT_ACC = 4'h3,
    LMIS_OP_ACC_FILE = 4'h4,
    LMIS_OP_IND_STORE = 4'h5,
    LMIS_OP_IND_REL = 4'h6,
    LMIS_OP_OPTION = 4'h7,
    LMIS_OP_SRESET = 4'h8
  } lmis_op_t;
  typedef enum logic [1:0] {
    LMIS_ST_RUN = 2'b00,
    LMIS_ST_RESET = 2'b01
  } lmis_state_t;
endpackage

// *** verilog/lmis_ptr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface lmis_ptr_if;
  logic [15:0] ptr;
  logic [1:0] mode;
  logic rel;
  logic [5:0] ofs;
  logic [15:0] addr;
  logic [15:0] next_ptr;
  modport calc (input ptr, mode, rel, ofs, output addr, next_ptr);
  modport user (output ptr, mode, rel, ofs, input addr, next_ptr);
endinterface
`default_nettype wire

// *** verilog/lmis_ptr_calc.sv ***
`include "lmis_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lmis_ptr_calc
  import lmis_pkg::*;
(
  lmis_ptr_if.calc p
);
  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] sofs;
  assign inc = p.ptr + 16'h0001;
  assign dec = p.ptr - 16'h0001;
  assign sofs = {{10{p.ofs[5]}}, p.ofs};
  always_comb
  begin
    p.addr = p.ptr;
    p.next_ptr = p.ptr;
    if (p.rel)
    begin
      p.addr = p.ptr + sofs;
    end
    else
    begin
      case (p.mode)
        `LMIS_MODE_PREINC:
        begin
          p.addr = inc;
          p.next_ptr = inc;
        end
        `LMIS_MODE_PREDEC:
        begin
          p.addr = dec;
          p.next_ptr = dec;
        end
        `LMIS_MODE_POSTINC:
        begin
          p.addr = p.ptr;
          p.next_ptr = inc;
        end
        default:
        begin
          p.addr = p.ptr;
          p.next_ptr = dec;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verilog/lmis_core.sv ***
`include "lmis_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module lmis_core
  import lmis_pkg::*;
#(
  parameter int VIRT_ADDR0 = 0,
  parameter int VIRT_ADDR1 = 1
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire lmis_op_t i_op,
  input wire logic [7:0] i_lit,
  input wire logic i_sel,
  input wire logic [1:0] i_mode,
  input wire logic [5:0] i_ofs,
  input wire logic i_rfl_set,
  output logic o_done,
  output logic o_pc_adv,
  output logic [`LMIS_BANK_W-1:0] o_bank_selector,
  output logic [`LMIS_PAGE_W-1:0] o_pc_high_latch,
  output logic [7:0] o_acc,
  output logic [7:0] o_option,
  output logic [`LMIS_PTR_W-1:0] o_ptr0,
  output logic [`LMIS_PTR_W-1:0] o_ptr1,
  output logic o_wr,
  output logic [15:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_reset_instruction_flag_n,
  output logic o_sreset
);
  // refuse file addresses out of range and reset lengths rcnt cannot hold
  if (VIRT_ADDR0 < 0 || VIRT_ADDR0 > 127 || VIRT_ADDR1 < 0
      || VIRT_ADDR1 > 127 || VIRT_ADDR0 == VIRT_ADDR1
      || `LMIS_SRST_CYCLES < 1 || `LMIS_SRST_CYCLES > 4)
  begin
    $error("bad virtual indirect address or reset length");
  end
  lmis_state_t state;
  logic [1:0] rcnt;
  logic go;
  logic [15:0] sel_ptr;
  logic [15:0] file_addr;
  lmis_ptr_if pif ();
  assign go = i_valid && state == LMIS_ST_RUN;
  assign sel_ptr = i_sel ? o_ptr1 : o_ptr0;
  assign pif.ptr = sel_ptr;
  assign pif.mode = i_mode;
  assign pif.rel = (i_op == LMIS_OP_IND_REL);
  assign pif.ofs = i_ofs;
  lmis_ptr_calc u_calc (.p(pif));
  always_comb
  begin
    file_addr = {9'h000, i_lit[6:0]};
    if (i_lit[6:0] == 7'(VIRT_ADDR0))
    begin
      file_addr = o_ptr0;
    end
    else if (i_lit[6:0] == 7'(VIRT_ADDR1))
    begin
      file_addr = o_ptr1;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= LMIS_ST_RUN;
      rcnt <= 2'b00;
      o_sreset <= 1'b0;
    end
    else
    begin
      case (state)
        LMIS_ST_RUN:
        begin
          if (go && i_op == LMIS_OP_SRESET)
          begin
            state <= LMIS_ST_RESET;
            rcnt <= 2'(`LMIS_SRST_CYCLES - 1);
            o_sreset <= 1'b1;
          end
        end
        LMIS_ST_RESET:
        begin
          if (rcnt == 2'b00)
          begin
            state <= LMIS_ST_RUN;
            o_sreset <= 1'b0;
          end
          else
          begin
            rcnt <= rcnt - 2'b01;
          end
        end
        default:
        begin
          state <= LMIS_ST_RUN;
        end
      endcase
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_reset_instruction_flag_n <= 1'b1;
    end
    else if (go && i_op == LMIS_OP_SRESET)
    begin
      o_reset_instruction_flag_n <= 1'b0;
    end
    else if (i_rfl_set)
    begin
      o_reset_instruction_flag_n <= 1'b1;
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_bank_selector <= `LMIS_BANK_RST;
      o_pc_high_latch <= `LMIS_PAGE_RST;
      o_acc <= `LMIS_ACC_RST;
      o_option <= `LMIS_OPT_RST;
    end
    else if (o_sreset)
    begin
      o_bank_selector <= `LMIS_BANK_RST;
      o_pc_high_latch <= `LMIS_PAGE_RST;
      o_acc <= `LMIS_ACC_RST;
      o_option <= `LMIS_OPT_RST;
    end
    else if (go)
    begin
      case (i_op)
        LMIS_OP_LIT_BANK: o_bank_selector <= i_lit[4:0];
        LMIS_OP_LIT_PAGE: o_pc_high_latch <= i_lit[6:0];
        LMIS_OP_LIT_ACC: o_acc <= i_lit;
        LMIS_OP_OPTION: o_option <= o_acc;
        default:
        begin
        end
      endcase
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ptr0 <= `LMIS_PTR_RST;
      o_ptr1 <= `LMIS_PTR_RST;
    end
    else if (o_sreset)
    begin
      o_ptr0 <= `LMIS_PTR_RST;
      o_ptr1 <= `LMIS_PTR_RST;
    end
    else if (go && i_op == LMIS_OP_IND_STORE)
    begin
      if (i_sel)
      begin
        o_ptr1 <= pif.next_ptr;
      end
      else
      begin
        o_ptr0 <= pif.next_ptr;
      end
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wr <= 1'b0;
      o_wr_addr <= 16'h0000;
      o_wr_data <= 8'h00;
      o_done <= 1'b0;
      o_pc_adv <= 1'b0;
    end
    else
    begin
      o_wr <= 1'b0;
      o_done <= go && i_op != LMIS_OP_SRESET;
      o_pc_adv <= go && i_op != LMIS_OP_SRESET;
      if (go && i_op == LMIS_OP_ACC_FILE)
      begin
        o_wr <= 1'b1;
        o_wr_addr <= file_addr;
        o_wr_data <= o_acc;
      end
      else if (go && (i_op == LMIS_OP_IND_STORE || i_op == LMIS_OP_IND_REL))
      begin
        o_wr <= 1'b1;
        o_wr_addr <= pif.addr;
        o_wr_data <= o_acc;
      end
    end
  end
  a_bank_load: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_LIT_BANK |=> o_bank_selector == $past(i_lit[4:0]))
    else $error("bank selector not loaded");
  a_page_load: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_LIT_PAGE |=> o_pc_high_latch == $past(i_lit[6:0]))
    else $error("page latch not loaded");
  a_acc_load: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_LIT_ACC |=> o_acc == $past(i_lit) && o_done)
    else $error("accumulator not loaded");
  a_file_write: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_ACC_FILE |=> o_wr && o_wr_data == $past(o_acc))
    else $error("file write missing");
  a_preinc_addr: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_IND_STORE && i_mode == 2'b00 && !i_sel
    |=> o_wr_addr == $past(o_ptr0) + 16'h0001 && o_ptr0 == o_wr_addr)
    else $error("preincrement wrong");
  a_postdec_addr: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_IND_STORE && i_mode == 2'b11 && i_sel
    |=> o_wr_addr == $past(o_ptr1) && o_ptr1 == o_wr_addr - 16'h0001)
    else $error("postdecrement wrong");
  a_rel_keep: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_IND_REL |=> $stable(o_ptr0) && $stable(o_ptr1))
    else $error("relative mode moved pointer");
  a_ind_regs_keep: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && (i_op == LMIS_OP_IND_STORE || i_op == LMIS_OP_IND_REL)
    |=> $stable(o_acc) && $stable(o_bank_selector) && $stable(o_option))
    else $error("indirect store touched other state");
  a_option_copy: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_OPTION |=> o_option == $past(o_acc))
    else $error("option not copied");
  a_sreset_flag: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_SRESET
    |=> !o_reset_instruction_flag_n && o_sreset ##2 !o_sreset)
    else $error("software reset wrong");
  a_nop_still: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_NOP |=> o_pc_adv && !o_wr && $stable(o_acc))
    else $error("nop changed state");
  c_ind_store: cover property (@(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_IND_STORE);
  c_rel_store: cover property (@(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_IND_REL);
  c_wrap: cover property (@(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_IND_STORE && o_ptr0 == 16'hFFFF);
  c_sreset: cover property (@(posedge i_mclk) disable iff (i_rst)
    go && i_op == LMIS_OP_SRESET);
endmodule
`default_nettype wire

// *** test/test_literal_move_indirect_store_ops.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_literal_move_indirect_store_ops;
  import lmis_pkg::*;
  logic i_mclk, i_rst, i_valid, i_sel, i_rfl_set;
  lmis_op_t i_op;
  logic [7:0] i_lit;
  logic [1:0] i_mode;
  logic [5:0] i_ofs;
  logic o_done, o_pc_adv, o_wr, o_flag_n, o_sreset;
  logic [4:0] o_bank;
  logic [6:0] o_page;
  logic [7:0] o_acc, o_option, o_wr_data;
  logic [15:0] o_ptr0, o_ptr1, o_wr_addr;
  logic [7:0] acc;
  int failures, checks;

  lmis_core uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_valid(i_valid),
    .i_op(i_op), .i_lit(i_lit), .i_sel(i_sel), .i_mode(i_mode),
    .i_ofs(i_ofs), .i_rfl_set(i_rfl_set), .o_done(o_done),
    .o_pc_adv(o_pc_adv), .o_bank_selector(o_bank),
    .o_pc_high_latch(o_page), .o_acc(o_acc), .o_option(o_option),
    .o_ptr0(o_ptr0), .o_ptr1(o_ptr1), .o_wr(o_wr), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data), .o_reset_instruction_flag_n(o_flag_n),
    .o_sreset(o_sreset));

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one instruction, then its one-cycle answer
  task automatic do_op(input lmis_op_t op, input logic [7:0] lit,
    input logic s, input logic [1:0] m, input logic [5:0] o,
    input logic ew, input logic [15:0] ea);
    i_op <= op;
    i_lit <= lit;
    i_sel <= s;
    i_mode <= m;
    i_ofs <= o;
    i_valid <= 1'b1;
    @(posedge i_mclk);
    i_valid <= 1'b0;
    #1;
    chk(o_done, 16'h0001);
    chk(o_pc_adv, 16'h0001);
    chk(o_wr, {15'h0000, ew});
    if (ew)
    begin
      chk(o_wr_addr, ea);
      chk(o_wr_data, acc);
    end
    @(posedge i_mclk);
  endtask

  task automatic t_reset;
    chk(o_acc, 16'h0000);
    chk(o_option, 16'h00ff);
    chk(o_ptr0, 16'h0000);
    chk(o_flag_n, 16'h0001);
    chk(o_wr, 16'h0000);
  endtask

  task automatic t_literals;
    do_op(LMIS_OP_LIT_BANK, 8'h0f, 0, 0, 0, 0, 0);
    chk(o_bank, 16'h000f);
    do_op(LMIS_OP_LIT_PAGE, 8'h7f, 0, 0, 0, 0, 0);
    chk(o_page, 16'h007f);
    acc = 8'h5a;
    do_op(LMIS_OP_LIT_ACC, acc, 0, 0, 0, 0, 0);
    chk(o_acc, acc);
  endtask

  // walk pointer 0 across both ends of its range
  task automatic t_store_modes;
    do_op(LMIS_OP_IND_STORE, 0, 0, 2'b01, 0, 1, 16'hffff);
    chk(o_ptr0, 16'hffff);
    do_op(LMIS_OP_IND_STORE, 0, 0, 2'b00, 0, 1, 16'h0000);
    chk(o_ptr0, 16'h0000);
    do_op(LMIS_OP_IND_STORE, 0, 0, 2'b11, 0, 1, 16'h0000);
    chk(o_ptr0, 16'hffff);
    do_op(LMIS_OP_IND_STORE, 0, 0, 2'b10, 0, 1, 16'hffff);
    chk(o_ptr0, 16'h0000);
    do_op(LMIS_OP_IND_STORE, 0, 1, 2'b10, 0, 1, 16'h0000);
    chk(o_ptr1, 16'h0001);
    chk(o_ptr0, 16'h0000);
  endtask

  task automatic t_relative;
    do_op(LMIS_OP_IND_REL, 0, 1, 2'b11, 6'h20, 1, 16'hffe1);
    chk(o_ptr1, 16'h0001);
    do_op(LMIS_OP_IND_REL, 0, 1, 2'b00, 6'h1f, 1, 16'h0020);
    chk(o_ptr1, 16'h0001);
  endtask

  task automatic t_file;
    do_op(LMIS_OP_ACC_FILE, 8'ha5, 0, 0, 0, 1, 16'h0025);
    do_op(LMIS_OP_IND_STORE, 0, 1, 2'b00, 0, 1, 16'h0002);
    do_op(LMIS_OP_ACC_FILE, 8'h01, 0, 0, 0, 1, 16'h0002);
  endtask

  task automatic t_option_nop;
    acc = 8'hc3;
    do_op(LMIS_OP_LIT_ACC, acc, 0, 0, 0, 0, 0);
    do_op(LMIS_OP_OPTION, 0, 0, 0, 0, 0, 0);
    chk(o_option, 16'h00c3);
    do_op(LMIS_OP_NOP, 8'hff, 1, 2'b11, 6'h3f, 0, 0);
    chk(o_acc, acc);
    chk(o_bank, 16'h000f);
    chk(o_ptr1, 16'h0002);
    do_op(LMIS_OP_IND_STORE, 0, 1, 2'b11, 0, 1, 16'h0002);
    chk(o_ptr1, 16'h0001);
  endtask

  // an instruction offered mid-reset must be dropped
  task automatic t_sreset;
    i_op <= LMIS_OP_SRESET;
    i_valid <= 1'b1;
    @(posedge i_mclk);
    i_op <= LMIS_OP_LIT_ACC;
    i_lit <= 8'h77;
    #1;
    chk(o_sreset, 16'h0001);
    chk(o_flag_n, 16'h0000);
    @(posedge i_mclk);
    i_valid <= 1'b0;
    #1;
    chk(o_sreset, 16'h0001);
    @(posedge i_mclk);
    #1;
    chk(o_sreset, 16'h0000);
    chk(o_done, 16'h0000);
    chk(o_acc, 16'h0000);
    chk(o_bank, 16'h0000);
    chk(o_option, 16'h00ff);
    chk(o_ptr1, 16'h0000);
    chk(o_flag_n, 16'h0000);
    @(posedge i_mclk);
    i_rfl_set <= 1'b1;
    @(posedge i_mclk);
    i_rfl_set <= 1'b0;
    #1;
    chk(o_flag_n, 16'h0001);
    @(posedge i_mclk);
  endtask

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  initial
  begin
    failures = 0;
    checks = 0;
    acc = 8'h00;
    i_rst = 1'b1;
    i_valid = 1'b0;
    i_sel = 1'b0;
    i_rfl_set = 1'b0;
    i_op = LMIS_OP_NOP;
    i_lit = 8'h00;
    i_mode = 2'b00;
    i_ofs = 6'h00;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_reset();
    t_literals();
    t_store_modes();
    t_relative();
    t_file();
    t_option_nop();
    t_sreset();
    end_sim();
  end
endmodule
`default_nettype wire
